// ---- card_reader_irq_and_mode_ctrl.sv ----
// Mode, switch and interrupt control of the card reader bridge
`timescale 1ns/1ps
`include "cr_defs.svh"

module card_reader_irq_and_mode_ctrl
	import cr_pkg::*;
#(
	parameter int unsigned PULSE_CYCLES = `IRQ_PULSE_CYCLES
)
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Control straps and pins
	input  wire logic       serial_sel,
	input  wire logic       mode_pin,
	input  wire logic       shutdown_hold,
	// Register port from the serial slave
	input  wire reg_req_t   reg_req,
	output logic      [7:0] reg_rdata,
	// Event sources
	input  wire sense_t     sense,
	// Shared error and interrupt pin
	output logic            error_event_pin_o,
	output logic            error_event_pin_oe,
	// Busy and switch outputs
	output logic            busy_n,
	output logic            port1_switch_closed,
	output logic            port2_switch_closed,
	output logic      [1:0] reader_card_sel
);
	logic                    strap_taken_reg;
	logic                    sel_reg;
	logic [4:0]              ctrl_reg;
	logic [1:0]              cfg_reg;
	logic [7:0]              en_lo_reg;
	logic [7:0]              en_hi_reg;
	logic [7:0]              req_reg;
	logic [7:0]              req_next;
	logic [7:0]              status_prev_reg;
	logic [7:0]              status_live;
	logic [7:0]              chg;
	logic [7:0]              en_vec;
	logic                    mode_prev_reg;
	logic                    mode_fall;
	logic                    active;
	logic                    err_live;
	logic                    fire;
	logic                    status_rd;
	logic                    int_latch_reg;
	logic [`PULSE_CNT_W-1:0] pulse_cnt_reg;
	logic                    int_act;
	logic                    wake;
	logic                    pulse_mode;
	reader_state_t           state_reg;
	reader_state_t           state_next;
	reader_state_t           target;

	assign wake       = ctrl_reg[`CTL_WAKE_BIT];
	assign pulse_mode = cfg_reg[`CFG_PULSE_BIT];
	assign active     = (state_reg != ST_PASS);
	assign mode_fall  = mode_prev_reg & ~mode_pin;
	assign status_rd  = reg_req.rd && (reg_req.addr == `OFS_LIVE_EVENT_STATUS);

	// Strap is sampled once after reset release, never inside the reset branch
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			strap_taken_reg <= 1'b0;
			sel_reg         <= 1'b0;
		end
		else if (!strap_taken_reg)
		begin
			strap_taken_reg <= 1'b1;
			sel_reg         <= serial_sel;
		end
	end

	// Register writes; reserved control bits are not stored
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_reg  <= `RST_CONTROL;
			cfg_reg   <= `RST_CONFIG;
			en_lo_reg <= `RST_ENABLE;
			en_hi_reg <= `RST_ENABLE;
		end
		else if (reg_req.wr)
		begin
			unique case (reg_req.addr)
				`OFS_MODE_SWITCH_CONTROL: ctrl_reg  <= reg_req.wdata[4:0];
				`OFS_FIRST_CONFIG_REG:    cfg_reg   <= reg_req.wdata[1:0];
				`OFS_IRQ_ENABLE_LO:       en_lo_reg <= reg_req.wdata;
				`OFS_IRQ_ENABLE_HI:       en_hi_reg <= reg_req.wdata;
				default:                  ;
			endcase
		end
	end

	// Reader mode target; a card change goes through pass-through so busy toggles
	always_comb
	begin
		target = ST_PASS;
		if (sel_reg)
		begin
			if (wake && ctrl_reg[2:1] == `CARD_SEL_1)
				target = ST_CARD1;
			else if (wake && ctrl_reg[2:1] == `CARD_SEL_2)
				target = ST_CARD2;
		end
		else if (mode_pin && !(state_reg == ST_CARD1 && mode_fall))
			target = ST_CARD1;
		else if (state_reg == ST_CARD1 && !mode_fall)
			target = ST_CARD1;
		state_next = state_reg;
		if (strap_taken_reg && target != state_reg)
		begin
			// Faults never force an exit; only the host does
			if (active && shutdown_hold)
				state_next = state_reg;
			else if (active)
				state_next = ST_PASS;
			else
				state_next = target;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg     <= ST_PASS;
			mode_prev_reg <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			mode_prev_reg <= mode_pin;
		end
	end

	// Fault conditions count only while the reader owns a card
	assign err_live = active & (sense.reader_fault | ~sense.bus_power | ~sense.term_supply
		| ~sense.card_supply);

	always_comb
	begin
		status_live                  = 8'h00;
		status_live[`EV_USB_CONN]    = sense.usb_connected;
		status_live[`EV_USB_SUSPEND] = sense.usb_suspended;
		status_live[`EV_BUS_POWER]   = sense.bus_power;
		status_live[`EV_CARD_SUPPLY] = sense.card_supply;
		status_live[`EV_TERM_SUPPLY] = sense.term_supply;
		status_live[`EV_BUSY]        = active;
		status_live[`EV_CARD]        = sense.card_present & active;
		status_live[`EV_ERROR]       = err_live;
		chg                          = status_live ^ status_prev_reg;
		// Entering or leaving reader mode is not a card event
		chg[`EV_CARD]                = chg[`EV_CARD] & active & status_prev_reg[`EV_BUSY];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			status_prev_reg <= 8'h00;
		else
			status_prev_reg <= status_live;
	end

	// Requests record every change, masked or not; a new change beats a clearing read
	always_comb
	begin
		req_next = req_reg;
		if (reg_req.rd && reg_req.addr == `OFS_IRQ_REQUEST_LO)
			req_next[6:0] = 7'h00;
		if (reg_req.rd && reg_req.addr == `OFS_IRQ_REQUEST_HI)
			req_next[`EV_ERROR] = 1'b0;
		req_next = req_next | chg;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			req_reg <= 8'h00;
		else
			req_reg <= req_next;
	end

	assign en_vec = {en_hi_reg[0], en_lo_reg[6:0]};
	assign fire   = sel_reg & (|(chg & en_vec));

	// Latched form clears on a status read; a fresh event in that cycle wins
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			int_latch_reg <= 1'b0;
		else if (fire)
			int_latch_reg <= 1'b1;
		else if (status_rd)
			int_latch_reg <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pulse_cnt_reg <= '0;
		else if (fire)
			pulse_cnt_reg <= `PULSE_CNT_W'(PULSE_CYCLES);
		else if (pulse_cnt_reg != '0)
			pulse_cnt_reg <= pulse_cnt_reg - `PULSE_CNT_W'(1);
	end

	assign int_act = pulse_mode ? (pulse_cnt_reg != '0) : int_latch_reg;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			error_event_pin_o  <= 1'b1;
			error_event_pin_oe <= 1'b0;
		end
		else if (!strap_taken_reg)
		begin
			error_event_pin_o  <= 1'b1;
			error_event_pin_oe <= 1'b0;
		end
		else if (sel_reg)
		begin
			error_event_pin_oe <= wake;
			error_event_pin_o  <= cfg_reg[`CFG_POL_BIT] ? int_act : ~int_act;
		end
		else
		begin
			error_event_pin_oe <= 1'b1;
			error_event_pin_o  <= ~err_live;
		end
	end

	// Outputs follow the next state so busy and the status bit agree each cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			busy_n              <= 1'b1;
			port1_switch_closed <= 1'b1;
			port2_switch_closed <= 1'b1;
			reader_card_sel     <= 2'h0;
		end
		else
		begin
			busy_n              <= (state_next == ST_PASS);
			port1_switch_closed <= ctrl_reg[`CTL_PORT1_BIT] & (state_next != ST_CARD1);
			port2_switch_closed <= ctrl_reg[`CTL_PORT2_BIT] & (state_next != ST_CARD2);
			reader_card_sel     <= {state_next == ST_CARD2, state_next == ST_CARD1};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_req.rd)
		begin
			unique case (reg_req.addr)
				`OFS_MODE_SWITCH_CONTROL: reg_rdata <= {3'h0, ctrl_reg};
				`OFS_FIRST_CONFIG_REG:    reg_rdata <= {6'h00, cfg_reg};
				`OFS_IRQ_ENABLE_LO:       reg_rdata <= en_lo_reg;
				`OFS_IRQ_ENABLE_HI:       reg_rdata <= en_hi_reg;
				`OFS_IRQ_REQUEST_LO:      reg_rdata <= {1'b0, req_reg[6:0]};
				`OFS_IRQ_REQUEST_HI:      reg_rdata <= {7'h00, req_reg[`EV_ERROR]};
				`OFS_LIVE_EVENT_STATUS:   reg_rdata <= status_live;
				default:                  reg_rdata <= 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_reset_masked;
		$rose(rst_n) |-> en_lo_reg == 8'h00 && en_hi_reg == 8'h00 && req_reg == 8'h00;
	endproperty
	a_reset_masked: assert property (p_reset_masked) else $error("enables not cleared");

	property p_busy_match;
		##1 busy_n == (state_reg == ST_PASS);
	endproperty
	a_busy_match: assert property (p_busy_match) else $error("busy pin and bit differ");

	property p_sleep_release;
		strap_taken_reg && sel_reg && !wake |=> !error_event_pin_oe;
	endproperty
	a_sleep_release: assert property (p_sleep_release) else $error("pin driven in sleep");

	property p_int_level;
		strap_taken_reg && sel_reg && wake && int_act |=>
			error_event_pin_o == $past(cfg_reg[`CFG_POL_BIT]);
	endproperty
	a_int_level: assert property (p_int_level) else $error("wrong interrupt level");

	property p_pulse_len;
		fire && pulse_mode ##1 !fire [*3] |-> pulse_cnt_reg == `PULSE_CNT_W'(PULSE_CYCLES - 2);
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse count wrong");

	property p_req_clear;
		reg_req.rd && reg_req.addr == `OFS_IRQ_REQUEST_LO && chg[6:0] == 7'h00
			|=> req_reg[6:0] == 7'h00;
	endproperty
	a_req_clear: assert property (p_req_clear) else $error("request not cleared");

	property p_masked_record;
		chg[`EV_USB_SUSPEND] && !en_lo_reg[`EV_USB_SUSPEND] |=> req_reg[`EV_USB_SUSPEND];
	endproperty
	a_masked_record: assert property (p_masked_record) else $error("masked change lost");

	property p_card_pass;
		state_reg == ST_PASS |-> !chg[`EV_CARD];
	endproperty
	a_card_pass: assert property (p_card_pass) else $error("card event in pass-through");

	property p_switch_ignored;
		state_reg == ST_CARD1 && state_next == ST_CARD1 |=> !port1_switch_closed;
	endproperty
	a_switch_ignored: assert property (p_switch_ignored) else $error("port 1 switch closed");

	property p_simple_leave;
		strap_taken_reg && !sel_reg && state_reg == ST_CARD1 && mode_fall && !shutdown_hold
			|=> state_reg == ST_PASS && busy_n;
	endproperty
	a_simple_leave: assert property (p_simple_leave) else $error("mode fall ignored");

	property p_error_low;
		strap_taken_reg && !sel_reg && err_live |=> error_event_pin_oe && !error_event_pin_o;
	endproperty
	a_error_low: assert property (p_error_low) else $error("error not signalled");

	c_card1_entry: cover property (state_reg == ST_PASS ##1 state_reg == ST_CARD1);
	c_card_swap:   cover property (state_reg == ST_CARD1 ##[1:4] state_reg == ST_CARD2);
	c_fire_clear:  cover property (fire ##[1:20] status_rd);
	c_sleep_wake:  cover property (!error_event_pin_oe ##1 error_event_pin_oe);
endmodule

// ---- cr_defs.svh ----
// Register offsets, field positions, reset values and timing of the reader control block
`ifndef CR_DEFS_SVH
`define CR_DEFS_SVH
`define OFS_MODE_SWITCH_CONTROL 8'h00
`define OFS_FIRST_CONFIG_REG    8'h01
`define OFS_IRQ_ENABLE_LO       8'h04
`define OFS_IRQ_ENABLE_HI       8'h05
`define OFS_IRQ_REQUEST_LO      8'h10
`define OFS_IRQ_REQUEST_HI      8'h11
`define OFS_LIVE_EVENT_STATUS   8'h12
`define RST_CONTROL             5'h18
`define RST_CONFIG              2'h0
`define RST_ENABLE              8'h00
`define CTL_WAKE_BIT            0
`define CTL_CARD_LSB            1
`define CTL_PORT1_BIT           3
`define CTL_PORT2_BIT           4
`define CFG_POL_BIT             0
`define CFG_PULSE_BIT           1
`define EV_USB_CONN             0
`define EV_USB_SUSPEND          1
`define EV_BUS_POWER            2
`define EV_CARD_SUPPLY          3
`define EV_TERM_SUPPLY          4
`define EV_BUSY                 5
`define EV_CARD                 6
`define EV_ERROR                7
`define CARD_SEL_1              2'h1
`define CARD_SEL_2              2'h2
`define IRQ_PULSE_NS            10000000
`define CLK_PERIOD_NS           5
`define IRQ_PULSE_CYCLES        (`IRQ_PULSE_NS / `CLK_PERIOD_NS)
`define PULSE_CNT_W             21
`endif

// ---- cr_pkg.sv ----
// Types shared by the reader control block
package cr_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic       bus_power;
		logic       card_supply;
		logic       term_supply;
		logic       usb_connected;
		logic       usb_suspended;
		logic       card_present;
		logic       reader_fault;
	} sense_t;

	typedef enum logic [2:0] {
		ST_PASS  = 3'b001,
		ST_CARD1 = 3'b010,
		ST_CARD2 = 3'b100
	} reader_state_t;
endpackage

// ---- host_model.sv ----
// Host processor model: register port, mode pin and pulled-up event pin
`timescale 1ns/1ps
module host_model
	import cr_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Register port
	output reg_req_t        reg_req,
	input  wire logic [7:0] reg_rdata,
	// Event pin and mode pin
	input  wire logic       pin_o,
	input  wire logic       pin_oe,
	input  wire logic       auto_drop,
	output logic            pin_level,
	output logic            mode_pin
);
	// Board pull-up gives the level while the device lets go
	assign pin_level = pin_oe ? pin_o : 1'b1;

	initial
	begin
		reg_req  = '0;
		mode_pin = 1'b0;
	end

	// A reported error sends the device back to pass-through
	always @(negedge clk)
		if (auto_drop && pin_level === 1'b0)
			mode_pin <= 1'b0;

	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w,
		output logic [7:0] q);
		@(negedge clk);
		reg_req.addr  = a;
		reg_req.wdata = (a == 8'h00) ? {3'h0, d[4:0]} : d;
		reg_req.wr    = w;
		reg_req.rd    = !w;
		@(negedge clk);
		reg_req.wr = 1'b0;
		reg_req.rd = 1'b0;
		q          = reg_rdata;
	endtask
endmodule

// ---- card_reader_irq_and_mode_ctrl_tb.sv ----
// Self-checking bench for the reader control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module card_reader_irq_and_mode_ctrl_tb;
	import cr_pkg::*;
	localparam int PULSE = 20;
	localparam logic [7:0] ADDRS [8] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h10, 8'h11, 8'h12, 8'h20};
	localparam logic [7:0] RSTV  [8] = '{8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic       clk, rst_n, serial_sel, shutdown_hold, auto_drop, mode_pin, pin_level;
	logic       pin_o, pin_oe, busy_n, sw1, sw2;
	logic [1:0] card_sel;
	logic [7:0] rdata, q;
	reg_req_t   req;
	sense_t     sense, s;
	int         err_count, checks, seed, exp_req, act, n;

	card_reader_irq_and_mode_ctrl #(.PULSE_CYCLES(PULSE)) u_card_reader_irq_and_mode_ctrl (
		.clk(clk), .rst_n(rst_n), .serial_sel(serial_sel), .mode_pin(mode_pin),
		.shutdown_hold(shutdown_hold), .reg_req(req), .reg_rdata(rdata), .sense(sense),
		.error_event_pin_o(pin_o), .error_event_pin_oe(pin_oe), .busy_n(busy_n),
		.port1_switch_closed(sw1), .port2_switch_closed(sw2), .reader_card_sel(card_sel));

	host_model u_host_model (
		.clk(clk), .reg_req(req), .reg_rdata(rdata), .pin_o(pin_o), .pin_oe(pin_oe),
		.auto_drop(auto_drop), .pin_level(pin_level), .mode_pin(mode_pin));

	function automatic int stat_of(input sense_t x, input int a);
		return x.usb_connected | x.usb_suspended << 1 | x.bus_power << 2 | x.card_supply << 3
			| x.term_supply << 4 | a << 5 | (a & x.card_present) << 6
			| (a & (x.reader_fault | !x.bus_power | !x.term_supply | !x.card_supply)) << 7;
	endfunction

	task automatic finish_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Every change is recorded, masked or not; entering the reader does not touch the card bit
	task automatic drive(input sense_t x, input int a);
		int d;
		d = stat_of(x, a) ^ stat_of(sense, act);
		if (a != act)
			d &= 8'hBF;
		exp_req |= d;
		@(negedge clk);
		sense = x;
		act   = a;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host_model.access(a, d, 1'b1, q);
	endtask

	task automatic chk_regs();
		u_host_model.access(8'h10, 8'h00, 1'b0, q);
		`CHK("request lo", exp_req & 8'h7F, q)
		u_host_model.access(8'h11, 8'h00, 1'b0, q);
		`CHK("request hi", exp_req >> 7, q)
		u_host_model.access(8'h12, 8'h00, 1'b0, q);
		`CHK("live status", stat_of(sense, act), q)
		exp_req = 0;
	endtask

	task automatic wait_for(ref logic x, input logic v, input int lim);
		for (int i = 0; i < lim && x !== v; i++)
			@(negedge clk);
		`CHK("wait level", v, x)
		if (x !== v)
			finish_test();
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial
	begin
		repeat (100000) @(posedge clk);
		err_count++;
		finish_test();
	end

	initial
	begin
		{rst_n, shutdown_hold, auto_drop} = 3'h0;
		serial_sel = 1'b1;
		sense      = '0;
		seed       = 96;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		foreach (ADDRS[i])
		begin
			u_host_model.access(ADDRS[i], 8'h00, 1'b0, q);
			`CHK("reset value", RSTV[i], q)
		end
		`CHK("idle outputs", 5'h1C, {busy_n, sw1, sw2, card_sel})
		repeat (4)
		begin
			drive(sense_t'(7'($random(seed))), 0);
			chk_regs();
			`CHK("sleep pin", 1'b0, pin_oe)
		end
		wr(8'h04, 8'h01);
		wr(8'h01, 8'h01);
		wr(8'h00, 8'h19);
		s = sense;
		s.usb_connected = ~s.usb_connected;
		drive(s, 0);
		wait_for(pin_level, 1'b1, 6);
		repeat (5) @(negedge clk);
		`CHK("latched pin", 1'b1, pin_level)
		chk_regs();
		wait_for(pin_level, 1'b0, 6);
		s.usb_suspended = ~s.usb_suspended;
		drive(s, 0);
		repeat (5) @(negedge clk);
		`CHK("masked pin", 1'b0, pin_level)
		chk_regs();
		wr(8'h01, 8'h02);
		// The pin register takes the new polarity one edge after the write
		@(negedge clk);
		`CHK("low idle", 1'b1, pin_level)
		s.usb_connected = ~s.usb_connected;
		drive(s, 0);
		wait_for(pin_level, 1'b0, 6);
		for (n = 0; n < 100 && pin_level === 1'b0; n++)
			@(negedge clk);
		`CHK("pulse length", 1'b1, (n >= PULSE - 1 && n <= PULSE + 1))
		wr(8'h01, 8'h01);
		s.usb_connected = ~s.usb_connected;
		drive(s, 0);
		wait_for(pin_level, 1'b1, 6);
		wr(8'h00, 8'h18);
		wait_for(pin_oe, 1'b0, 6);
		chk_regs();
		s = '{bus_power: 1, card_supply: 1, term_supply: 1, default: 0};
		drive(s, 0);
		chk_regs();
		wr(8'h00, 8'h1B);
		drive(s, 1);
		wait_for(busy_n, 1'b0, 6);
		`CHK("card one", 4'h5, {card_sel, sw1, sw2})
		wr(8'h00, 8'h0B);
		wait_for(sw2, 1'b0, 6);
		chk_regs();
		s.card_present = 1'b1;
		drive(s, 1);
		chk_regs();
		s.bus_power = 1'b0;
		drive(s, 1);
		chk_regs();
		`CHK("stay on error", 1'b0, busy_n)
		s.bus_power = 1'b1;
		drive(s, 1);
		wr(8'h00, 8'h1D);
		exp_req |= 8'h20;
		repeat (4) @(negedge clk);
		`CHK("card two", 5'h0A, {busy_n, card_sel, sw1, sw2})
		shutdown_hold = 1'b1;
		wr(8'h00, 8'h18);
		repeat (6) @(negedge clk);
		`CHK("held awake", 1'b0, busy_n)
		shutdown_hold = 1'b0;
		wait_for(busy_n, 1'b1, 6);
		drive(s, 0);
		chk_regs();
		rst_n      = 1'b0;
		serial_sel = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		act   = 0;
		@(negedge clk);
		u_host_model.mode_pin = 1'b1;
		wait_for(busy_n, 1'b0, 6);
		`CHK("simple entry", 4'h7, {card_sel, pin_oe, pin_level})
		s.reader_fault = 1'b1;
		drive(s, 1);
		wait_for(pin_level, 1'b0, 4);
		repeat (5) @(negedge clk);
		`CHK("stay on fault", 1'b0, busy_n)
		s.reader_fault = 1'b0;
		drive(s, 1);
		wait_for(pin_level, 1'b1, 4);
		auto_drop   = 1'b1;
		s.bus_power = 1'b0;
		drive(s, 1);
		wait_for(busy_n, 1'b1, 8);
		finish_test();
	end
endmodule
